/* hw/rsb_reset_boot.v */
// Purpose: reset generation, reset cause record, watchdog and flash boot sequencer
// Assumes: i_rst_n is power-on reset; own outputs never reset this block
// Notes: registers over AXI4-Lite; unit resets are plain held outputs
//
// Design decisions made here: the register addresses and the AXI4-Lite slave port.
`include "rsb_map.vh"
`default_nettype none
module rsb_reset_boot #(
    parameter [31:0] CHIP_VERSION = 32'h00000001, // arbitrary value
    parameter integer WAIT_CYC = `RSB_FLASH_WAIT_CYC
) (
    input wire i_clock,
    input wire i_rst_n,
    input wire [7:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output reg s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output reg s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    input wire [7:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output reg s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    input wire [3:0] i_boot_pins,
    input wire [6:0] i_config_pins,
    input wire [31:0] i_flash_data,
    input wire i_flash_ack,
    output reg o_sys_rst_n,
    output reg o_switch_rst_n,
    output reg o_core_rst_n,
    output reg o_tcm_rst_n,
    output reg o_sync_switch_rst,
    output reg o_sync_periph_rst,
    output reg o_sync_host_rst,
    output reg o_wd_expiry,
    output reg o_wd_prewarn_irq,
    output reg o_wd_prewarn_pin,
    output reg [3:0] o_dtcm_size,
    output reg [3:0] o_itcm_size,
    output reg o_boot_pins_as_addr,
    output reg [3:0] o_mem_timing,
    output reg o_burst_clk_en,
    output reg o_bank0_sel,
    output reg o_flash_rd,
    output reg [1:0] o_flash_width,
    output reg [31:0] o_branch_addr,
    output reg o_branch_valid
);
    // ==========================================================
    // bus slave
    reg [3:0] async_ctrl_q;
    reg [3:0] cause_q;
    reg [2:0] sync_ctrl_q;
    reg [1:0] wd_ctrl_q;
    reg [31:0] wd_period_q;
    reg [31:0] wd_prewarn_q;
    reg [15:0] pulse_len_q;
    reg [10:0] boot_q;
    reg [7:0] tcm_map_q;
    reg [31:0] wd_cnt_q;
    reg wd_expired_q;
    reg [15:0] pulse_cnt_q;
    reg [3:0] tgt_q;
    reg pulse_on_q;
    reg [2:0] st_q;
    reg [11:0] wait_q;
    reg boot_err_q;
    wire wr_go = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
    wire rd_go = s_axi_arvalid && !s_axi_rvalid;
    wire wr_full = (s_axi_wstrb == 4'hF);
    wire [7:0] ra = s_axi_araddr;
    wire [7:0] wa = s_axi_awaddr;
    reg wr_hit;
    reg [31:0] rd_val;
    reg rd_hit;
    // shared by read and write
    function is_mapped;
        input [7:0] a;
        begin
            is_mapped = (a <= `RSB_BRANCH_OFS) && (a[1:0] == 2'h0);
        end
    endfunction

    always @* begin
        wr_hit = is_mapped(wa);
        rd_hit = is_mapped(ra);
        rd_val = 32'h00000000;
        if (ra == `RSB_ID_OFS) begin
            rd_val = CHIP_VERSION;
        end else if (ra == `RSB_ASYNC_CTRL_OFS) begin
            rd_val = {28'h0, async_ctrl_q};
        end else if (ra == `RSB_CAUSE_OFS) begin
            rd_val = {28'h0, cause_q};
        end else if (ra == `RSB_SYNC_CTRL_OFS) begin
            rd_val = {29'h0, sync_ctrl_q};
        end else if (ra == `RSB_WD_CTRL_OFS) begin
            rd_val = {30'h0, wd_ctrl_q};
        end else if (ra == `RSB_WD_PERIOD_OFS) begin
            rd_val = wd_period_q;
        end else if (ra == `RSB_WD_PREWARN_OFS) begin
            rd_val = wd_prewarn_q;
        end else if (ra == `RSB_WD_RELOAD_OFS) begin
            rd_val = wd_cnt_q;
        end else if (ra == `RSB_PULSE_LEN_OFS) begin
            rd_val = {16'h0, pulse_len_q};
        end else if (ra == `RSB_BOOT_OFS) begin
            rd_val = {21'h0, boot_q};
        end else if (ra == `RSB_TCM_MAP_OFS) begin
            rd_val = {24'h0, tcm_map_q};
        end else if (ra == `RSB_MEM_CFG_OFS) begin
            rd_val = {27'h0, o_burst_clk_en, o_mem_timing};
        end else if (ra == `RSB_BOOT_STAT_OFS) begin
            rd_val = {26'h0, wd_expired_q, boot_err_q, 1'b0, st_q};
        end else if (ra == `RSB_BRANCH_OFS) begin
            rd_val = o_branch_addr;
        end
    end

    // partial-strobe writes are answered but dropped
    wire wr_ok = wr_go && wr_hit && wr_full;
    wire wr_async = wr_ok && (wa == `RSB_ASYNC_CTRL_OFS);
    wire req_sys = wr_async && s_axi_wdata[`RSB_AC_SYS_SW];
    wire req_switch = wr_async && s_axi_wdata[`RSB_AC_SWITCH_SW];
    wire req_core = wr_async && s_axi_wdata[`RSB_AC_CORE_SW];
    wire wr_reload = wr_ok && (wa == `RSB_WD_RELOAD_OFS);
    wire wr_wdctl = wr_ok && (wa == `RSB_WD_CTRL_OFS);
    wire wd_fire = wd_ctrl_q[`RSB_WC_RUN] && !wd_expired_q && (wd_cnt_q == 32'h00000000);
    wire wd_rst = wd_fire && wd_ctrl_q[`RSB_WC_RST_EN];
    wire pulse_end = pulse_on_q && (pulse_cnt_q <= 16'h0001);
    wire warn_d = wd_ctrl_q[`RSB_WC_RUN] && !wd_expired_q && !wr_reload && (wd_cnt_q <= wd_prewarn_q);

    always @(posedge i_clock) begin
        if (!i_rst_n) begin
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= 2'h0;
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rresp <= 2'h0;
            s_axi_rdata <= 32'h00000000;
        end else begin
            s_axi_awready <= wr_go;
            s_axi_wready <= wr_go;
            s_axi_arready <= rd_go;
            if (wr_go) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_hit ? 2'h0 : 2'h2;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
            if (rd_go) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp <= rd_hit ? 2'h0 : 2'h2;
                s_axi_rdata <= rd_val;
            end else if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // ==========================================================
    // control registers
    always @(posedge i_clock) begin
        if (!i_rst_n) begin
            async_ctrl_q <= 4'h8;
            sync_ctrl_q <= 3'h0;
            wd_ctrl_q <= 2'h0;
            wd_period_q <= `RSB_WD_PERIOD_RST;
            wd_prewarn_q <= `RSB_WD_PREWARN_RST;
            pulse_len_q <= `RSB_PULSE_LEN_RST;
            tcm_map_q <= `RSB_TCM_MAP_RST;
            o_mem_timing <= `RSB_MEM_TIMING_SLOW;
            o_burst_clk_en <= 1'b0;
        end else begin
            if (wr_async) begin
                async_ctrl_q <= {s_axi_wdata[`RSB_AC_INCLUDE], 3'h0};
            end
            // switch reset wins over a same-write clear
            if (req_switch || (pulse_on_q && tgt_q[3])) begin
                async_ctrl_q[`RSB_AC_INCLUDE] <= 1'b1;
            end
            if (wr_ok && wa == `RSB_SYNC_CTRL_OFS) begin
                sync_ctrl_q <= s_axi_wdata[2:0];
            end
            if (wr_wdctl) begin
                wd_ctrl_q <= s_axi_wdata[1:0];
            end
            if (wr_ok && wa == `RSB_WD_PERIOD_OFS) begin
                wd_period_q <= s_axi_wdata;
            end
            if (wr_ok && wa == `RSB_WD_PREWARN_OFS) begin
                wd_prewarn_q <= s_axi_wdata;
            end
            if (wr_ok && wa == `RSB_PULSE_LEN_OFS) begin
                pulse_len_q <= s_axi_wdata[15:0];
            end
            if (wr_ok && wa == `RSB_TCM_MAP_OFS) begin
                tcm_map_q <= s_axi_wdata[7:0];
            end
            if (wr_ok && wa == `RSB_MEM_CFG_OFS) begin
                o_mem_timing <= s_axi_wdata[3:0];
                o_burst_clk_en <= s_axi_wdata[4];
            end
        end
    end

    // ==========================================================
    // watchdog on the system clock; on input clock loss the pll
    // free-runs, so expiry still comes
    always @(posedge i_clock) begin
        if (!i_rst_n) begin
            wd_cnt_q <= `RSB_WD_PERIOD_RST;
            wd_expired_q <= 1'b0;
            o_wd_expiry <= 1'b0;
            o_wd_prewarn_irq <= 1'b0;
            o_wd_prewarn_pin <= 1'b0;
        end else begin
            o_wd_expiry <= wd_fire;
            if (wr_reload || (wr_wdctl && s_axi_wdata[`RSB_WC_RUN] && !wd_ctrl_q[`RSB_WC_RUN])) begin
                wd_cnt_q <= wd_period_q;
                wd_expired_q <= 1'b0;
            end else if (wd_fire) begin
                wd_expired_q <= 1'b1;
            end else if (wd_ctrl_q[`RSB_WC_RUN] && !wd_expired_q) begin
                wd_cnt_q <= wd_cnt_q - 32'h00000001;
            end
            // warning holds until reload or expiry
            o_wd_prewarn_irq <= warn_d;
            o_wd_prewarn_pin <= warn_d;
        end
    end

    // ==========================================================
    // reset pulse generator; targets {switch, tcm, core, sys}
    wire [3:0] new_tgt = {(wd_rst && async_ctrl_q[`RSB_AC_INCLUDE]) || req_switch,
        wd_rst || req_sys,
        wd_rst || req_sys || req_core,
        wd_rst || req_sys};
    always @(posedge i_clock) begin
        if (!i_rst_n) begin
            pulse_on_q <= 1'b0;
            pulse_cnt_q <= 16'h0000;
            tgt_q <= 4'h0;
            cause_q <= `RSB_CAUSE_POR_HW;
        end else begin
            if (new_tgt != 4'h0) begin
                pulse_on_q <= 1'b1;
                pulse_cnt_q <= pulse_len_q;
                tgt_q <= tgt_q | new_tgt;
            end else if (pulse_end) begin
                pulse_on_q <= 1'b0;
                tgt_q <= 4'h0;
            end else if (pulse_on_q) begin
                pulse_cnt_q <= pulse_cnt_q - 16'h0001;
            end
            // outside every reset it drives, so the record survives
            if (wd_rst) begin
                cause_q <= `RSB_CAUSE_WD;
            end else if (req_sys) begin
                cause_q <= `RSB_CAUSE_SYS_SW;
            end else if (req_core) begin
                cause_q <= `RSB_CAUSE_CORE_SW;
            end
        end
    end

    always @(posedge i_clock) begin
        if (!i_rst_n) begin
            o_sys_rst_n <= 1'b0;
            o_switch_rst_n <= 1'b0;
            o_core_rst_n <= 1'b0;
            o_tcm_rst_n <= 1'b0;
            o_sync_switch_rst <= 1'b0;
            o_sync_periph_rst <= 1'b0;
            o_sync_host_rst <= 1'b0;
            o_dtcm_size <= 4'h0;
            o_itcm_size <= 4'h0;
        end else begin
            o_sys_rst_n <= !(pulse_on_q && tgt_q[0]);
            o_core_rst_n <= !(pulse_on_q && tgt_q[1]);
            o_tcm_rst_n <= !(pulse_on_q && tgt_q[2]);
            o_switch_rst_n <= !(pulse_on_q && tgt_q[3]);
            // levels into the units' synchronous clears, never async pins
            o_sync_switch_rst <= sync_ctrl_q[0];
            o_sync_periph_rst <= sync_ctrl_q[1];
            o_sync_host_rst <= sync_ctrl_q[2];
            if (!o_core_rst_n) begin
                o_dtcm_size <= tcm_map_q[3:0];
                o_itcm_size <= tcm_map_q[7:4];
            end
        end
    end

    // ==========================================================
    // boot latch and flash boot sequencer
    always @(posedge i_clock) begin
        if (!i_rst_n) begin
            boot_q <= {i_config_pins, i_boot_pins};
        end
    end

    wire [1:0] width_sel = boot_q[5:4];
    always @(posedge i_clock) begin
        if (!i_rst_n) begin
            st_q <= `RSB_ST_WAIT;
            wait_q <= 12'h000;
            boot_err_q <= 1'b0;
            o_boot_pins_as_addr <= 1'b0;
            o_bank0_sel <= 1'b0;
            o_flash_rd <= 1'b0;
            o_flash_width <= `RSB_WIDTH_8;
            o_branch_addr <= 32'h00000000;
            o_branch_valid <= 1'b0;
        end else begin
            o_boot_pins_as_addr <= 1'b1;
            if (pulse_on_q && tgt_q[0]) begin
                // system reset reruns boot from the stored pins, no relatch
                st_q <= `RSB_ST_WAIT;
                wait_q <= 12'h000;
                o_bank0_sel <= 1'b0;
                o_flash_rd <= 1'b0;
                o_branch_valid <= 1'b0;
            end else begin
                case (st_q)
                    `RSB_ST_WAIT: begin
                        if (wait_q >= WAIT_CYC[11:0]) begin
                            if (boot_q[3:0] != `RSB_BOOT_FLASH) begin
                                st_q <= `RSB_ST_IDLE;
                            end else if (width_sel == `RSB_WIDTH_32 || width_sel == 2'h3) begin
                                st_q <= `RSB_ST_ERR;
                                boot_err_q <= 1'b1;
                            end else begin
                                st_q <= `RSB_ST_READ;
                                o_bank0_sel <= 1'b1;
                                o_flash_rd <= 1'b1;
                                o_flash_width <= width_sel;
                            end
                        end else begin
                            wait_q <= wait_q + 12'h001;
                        end
                    end
                    `RSB_ST_READ: begin
                        if (i_flash_ack) begin
                            o_branch_addr <= i_flash_data;
                            o_branch_valid <= 1'b1;
                            o_bank0_sel <= 1'b0;
                            o_flash_rd <= 1'b0;
                            st_q <= `RSB_ST_DONE;
                        end
                    end
                    default: begin
                        st_q <= st_q;
                    end
                endcase
            end
        end
    end
endmodule
`default_nettype wire

/* hw/rsb_map.vh */
// Purpose: offsets, fields, reset values and timing
// Assumes: one aligned 32-bit word per register
// Notes: included by bare name
`ifndef RSB_MAP_VH
`define RSB_MAP_VH
// ==========================================================
// register byte offsets
`define RSB_ID_OFS 8'h00
`define RSB_ASYNC_CTRL_OFS 8'h04
`define RSB_CAUSE_OFS 8'h08
`define RSB_SYNC_CTRL_OFS 8'h0C
`define RSB_WD_CTRL_OFS 8'h10
`define RSB_WD_PERIOD_OFS 8'h14
`define RSB_WD_PREWARN_OFS 8'h18
`define RSB_WD_RELOAD_OFS 8'h1C
`define RSB_PULSE_LEN_OFS 8'h20
`define RSB_BOOT_OFS 8'h24
`define RSB_TCM_MAP_OFS 8'h28
`define RSB_MEM_CFG_OFS 8'h2C
`define RSB_BOOT_STAT_OFS 8'h30
`define RSB_BRANCH_OFS 8'h34
// ==========================================================
// async reset control fields
`define RSB_AC_SYS_SW 0
`define RSB_AC_SWITCH_SW 1
`define RSB_AC_CORE_SW 2
`define RSB_AC_INCLUDE 3
// wd control fields
`define RSB_WC_RUN 0
`define RSB_WC_RST_EN 1
// cause codes, whole register is replaced
`define RSB_CAUSE_WD 4'h1
`define RSB_CAUSE_SYS_SW 4'h2
`define RSB_CAUSE_POR_HW 4'h4
`define RSB_CAUSE_CORE_SW 4'h8
// ==========================================================
// reset values
`define RSB_WD_PERIOD_RST 32'h0000FFFF
`define RSB_WD_PREWARN_RST 32'h00000100
`define RSB_PULSE_LEN_RST 16'h0010
`define RSB_MEM_TIMING_SLOW 4'hF
`define RSB_TCM_MAP_RST 8'h00
// ==========================================================
// boot selection
`define RSB_BOOT_FLASH 4'h0
`define RSB_WIDTH_8 2'h0
`define RSB_WIDTH_16 2'h1
`define RSB_WIDTH_32 2'h2
// ==========================================================
// timing
`define RSB_CLK_MHZ 25
`define RSB_FLASH_WAIT_NS 70000
`define RSB_FLASH_WAIT_CYC ((`RSB_FLASH_WAIT_NS * `RSB_CLK_MHZ + 999) / 1000)
// boot sequencer states
`define RSB_ST_IDLE 3'h0
`define RSB_ST_WAIT 3'h1
`define RSB_ST_READ 3'h2
`define RSB_ST_DONE 3'h3
`define RSB_ST_ERR 3'h4
`endif

/* testbench/rsb_reset_boot_asserts.sv */
// Purpose: port checks for the reset and boot block
// Assumes: one clock, i_rst_n synchronous active low
// Notes: bind at the foot
`default_nettype none
module rsb_checker #(
    parameter integer WAIT_CYC = 8
) (
    input wire logic i_clock,
    input wire logic i_rst_n,
    input wire logic [31:0] i_flash_data,
    input wire logic i_flash_ack,
    input wire logic o_sys_rst_n,
    input wire logic o_core_rst_n,
    input wire logic o_tcm_rst_n,
    input wire logic o_wd_expiry,
    input wire logic o_wd_prewarn_irq,
    input wire logic o_wd_prewarn_pin,
    input wire logic [3:0] o_dtcm_size,
    input wire logic o_boot_pins_as_addr,
    input wire logic o_bank0_sel,
    input wire logic o_flash_rd,
    input wire logic [1:0] o_flash_width,
    input wire logic [31:0] o_branch_addr,
    input wire logic o_branch_valid
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [15:0] since_q;
    logic warned_q;
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (!i_rst_n);
    // ==========================================================
    // helpers; the counter saturates
    always_ff @(posedge i_clock) begin
        if (!i_rst_n || !o_sys_rst_n) begin
            since_q <= 16'h0000;
        end else if (since_q != 16'hFFFF) begin
            since_q <= since_q + 16'h0001;
        end
        if (!i_rst_n || o_wd_expiry) begin
            warned_q <= 1'h0;
        end else if (o_wd_prewarn_irq) begin
            warned_q <= 1'h1;
        end
    end
    // ==========================================================
    // properties
    sequence s_read_start;
        $rose(o_flash_rd);
    endsequence
    property p_expiry_pulse;
        o_wd_expiry |=> !o_wd_expiry;
    endproperty
    a_expiry_pulse: assert property (p_expiry_pulse) else $error("expiry pulse too long");
    property p_prewarn_first;
        o_wd_expiry |-> warned_q;
    endproperty
    a_prewarn_first: assert property (p_prewarn_first) else $error("expiry without warning");
    property p_prewarn_pair;
        o_wd_prewarn_irq == o_wd_prewarn_pin;
    endproperty
    a_prewarn_pair: assert property (p_prewarn_pair) else $error("warning irq and pin differ");
    property p_read_start;
        s_read_start |-> since_q >= WAIT_CYC && o_bank0_sel && o_flash_width != 2'h2;
    endproperty
    a_read_start: assert property (p_read_start) else $error("bad flash read start");
    property p_branch;
        $rose(o_branch_valid) |-> $past(i_flash_ack) && o_branch_addr == $past(i_flash_data);
    endproperty
    a_branch: assert property (p_branch) else $error("branch not from flash word");
    property p_sys_group;
        !o_sys_rst_n |-> !o_core_rst_n && !o_tcm_rst_n;
    endproperty
    a_sys_group: assert property (p_sys_group) else $error("system reset incomplete");
    property p_tcm_cause;
        !o_tcm_rst_n |-> !o_sys_rst_n;
    endproperty
    a_tcm_cause: assert property (p_tcm_cause) else $error("memory reset alone");
    property p_size_hold;
        $changed(o_dtcm_size) |-> !$past(o_core_rst_n);
    endproperty
    a_size_hold: assert property (p_size_hold) else $error("size changed outside core reset");
    property p_pins_handover;
        $rose(i_rst_n) |=> o_boot_pins_as_addr;
    endproperty
    a_pins_handover: assert property (p_pins_handover) else $error("pins not handed over");
endmodule
bind rsb_reset_boot rsb_checker #(.WAIT_CYC(WAIT_CYC)) rsb_checker_inst (.*);
`default_nettype wire

/* testbench/rsb_flash_model.sv */
// Purpose: behavioural boot flash on bank 0
// Assumes: answers one read after i_delay cycles
// Notes: idle bus shows the inverted word
`default_nettype none
module rsb_flash_model (
    input wire logic i_clock,
    input wire logic i_sel,
    input wire logic i_rd,
    input wire logic [31:0] i_word0,
    input wire logic [3:0] i_delay,
    output logic o_ack,
    output logic [31:0] o_data
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [3:0] wait_q;
    logic done_q;
    // done_q: one answer per strobe
    always @(posedge i_clock) begin
        o_ack <= 1'h0;
        o_data <= ~i_word0;
        if (!(i_sel && i_rd)) begin
            wait_q <= 4'h0;
            done_q <= 1'h0;
        end else if (!done_q && wait_q >= i_delay) begin
            o_ack <= 1'h1;
            o_data <= i_word0;
            done_q <= 1'h1;
        end else if (!done_q) begin
            wait_q <= wait_q + 4'h1;
        end
    end
endmodule
`default_nettype wire

/* testbench/tb_top.sv */
// Purpose: self-checking bench for the reset and boot block
// Assumes: 25 MHz clock, flash wait shortened to 8 cycles
// Notes: AXI4-Lite tasks
`include "rsb_map.vh"
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    localparam integer WAIT = 8;
    localparam logic [31:0] VER = 32'h000000A5; // arbitrary value
    localparam logic [31:0] VEC = 32'h30001000;
    localparam logic [7:0] RA [9] = '{`RSB_ID_OFS, `RSB_CAUSE_OFS, `RSB_ASYNC_CTRL_OFS,
        `RSB_BOOT_OFS, `RSB_WD_PERIOD_OFS, `RSB_WD_PREWARN_OFS, `RSB_PULSE_LEN_OFS,
        `RSB_TCM_MAP_OFS, `RSB_SYNC_CTRL_OFS};
    localparam logic [31:0] RV [9] = '{VER, 32'h4, 32'h8, 32'h10, `RSB_WD_PERIOD_RST,
        `RSB_WD_PREWARN_RST, 32'h10, 32'h0, 32'h0};
    localparam logic [3:0] PINS [3] = '{4'h0, 4'h0, 4'h5};
    localparam logic [6:0] CFGS [3] = '{7'h00, 7'h02, 7'h01};
    localparam logic [31:0] STAT [3] = '{32'h3, 32'h14, 32'h0};
    logic i_clock = 1'h0;
    logic i_rst_n = 1'h0;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
    logic awready, wready, bvalid, arready, rvalid, fl_ack, sys_n, sw_n, core_n, tcm_n;
    logic s_sw, s_pe, s_ho, wd_x, irq, pin, as_addr, clk_en, bank0, fl_rd, br_valid;
    logic [1:0] bresp, rresp, width;
    logic [31:0] rdata, fl_data, branch;
    logic [3:0] pins = 4'h0, fl_delay = 4'h0, dsz, isz, timing;
    logic [6:0] cfg = 7'h01;
    int errors = 0, checks_done = 0, n, m, i;
    always #20 i_clock = ~i_clock;
    rsb_reset_boot #(
        .CHIP_VERSION(VER),
        .WAIT_CYC(WAIT)
    ) rsb_reset_boot_inst (
        .i_clock(i_clock), .i_rst_n(i_rst_n), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .i_boot_pins(pins), .i_config_pins(cfg), .i_flash_data(fl_data), .i_flash_ack(fl_ack),
        .o_sys_rst_n(sys_n), .o_switch_rst_n(sw_n), .o_core_rst_n(core_n), .o_tcm_rst_n(tcm_n),
        .o_sync_switch_rst(s_sw), .o_sync_periph_rst(s_pe), .o_sync_host_rst(s_ho),
        .o_wd_expiry(wd_x), .o_wd_prewarn_irq(irq), .o_wd_prewarn_pin(pin),
        .o_dtcm_size(dsz), .o_itcm_size(isz), .o_boot_pins_as_addr(as_addr),
        .o_mem_timing(timing), .o_burst_clk_en(clk_en), .o_bank0_sel(bank0), .o_flash_rd(fl_rd),
        .o_flash_width(width), .o_branch_addr(branch), .o_branch_valid(br_valid)
    );
    rsb_flash_model rsb_flash_model_inst (
        .i_clock(i_clock), .i_sel(bank0), .i_rd(fl_rd), .i_word0(VEC), .i_delay(fl_delay),
        .o_ack(fl_ack), .o_data(fl_data)
    );
    // ==========================================================
    // checking and closing
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            errors++;
            $display("CHECK FAILED t=%0t seen %h exp %h", $time, seen, exp);
        end
    endtask
    task automatic tally_and_finish();
        $display("checks %0d errors %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    task automatic lim(input int k, input int top);
        if (k >= top) begin
            errors++;
            tally_and_finish();
        end
    endtask
    // ==========================================================
    // bus tasks end at the edge that took the answer
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        @(posedge i_clock);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        bready <= 1'h1;
        for (n = 0; n < 50 && bvalid !== 1'h1; n++) begin
            @(posedge i_clock);
            if (awready === 1'h1) awvalid <= 1'h0;
            if (wready === 1'h1) wvalid <= 1'h0;
        end
        lim(n, 50);
        bready <= 1'h0;
        chk(32'(bresp), 32'(er));
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
        @(posedge i_clock);
        araddr <= a;
        arvalid <= 1'h1;
        rready <= 1'h1;
        for (n = 0; n < 50 && rvalid !== 1'h1; n++) begin
            @(posedge i_clock);
            if (arready === 1'h1) arvalid <= 1'h0;
        end
        lim(n, 50);
        rready <= 1'h0;
        chk(rdata, exp);
        chk(32'(rresp), 32'(er));
    endtask
    task automatic por(input logic [3:0] p, input logic [6:0] c, input logic [3:0] d);
        pins <= p;
        cfg <= c;
        fl_delay <= d;
        i_rst_n <= 1'h0;
        repeat (3) @(posedge i_clock);
        i_rst_n <= 1'h1;
    endtask
    // ==========================================================
    // scenarios
    initial begin
        por(4'h0, 7'h01, 4'h0);
        for (m = 0; m < 100 && fl_rd !== 1'h1; m++) @(posedge i_clock);
        lim(m, 100);
        chk(32'(m >= WAIT - 2), 32'h1);
        chk(32'({as_addr, bank0, width}), 32'hD);
        chk(32'({timing, clk_en}), 32'h1E);
        for (m = 0; m < 50 && br_valid !== 1'h1; m++) @(posedge i_clock);
        lim(m, 50);
        chk(branch, VEC);
        rd(`RSB_BRANCH_OFS, VEC, 2'h0);
        for (i = 0; i < 9; i++) rd(RA[i], RV[i], 2'h0);
        wr(`RSB_ID_OFS, 32'hFFFFFFFF, 2'h0);
        rd(`RSB_ID_OFS, VER, 2'h0);
        wr(8'h38, 32'h1, 2'h2);
        rd(8'h38, 32'h0, 2'h2);
        wr(`RSB_SYNC_CTRL_OFS, 32'h7, 2'h0);
        repeat (20) @(posedge i_clock);
        chk(32'({s_ho, s_pe, s_sw, sys_n}), 32'hF);
        rd(`RSB_SYNC_CTRL_OFS, 32'h7, 2'h0);
        wr(`RSB_SYNC_CTRL_OFS, 32'h0, 2'h0);
        repeat (3) @(posedge i_clock);
        chk(32'({s_ho, s_pe, s_sw}), 32'h0);
        wr(`RSB_TCM_MAP_OFS, 32'h21, 2'h0);
        wr(`RSB_PULSE_LEN_OFS, 32'h4, 2'h0);
        chk(32'({isz, dsz}), 32'h0);
        wr(`RSB_ASYNC_CTRL_OFS, 32'hC, 2'h0);
        for (m = 0; m < 10 && core_n !== 1'h0; m++) @(posedge i_clock);
        lim(m, 10);
        chk(32'({sys_n, tcm_n, sw_n}), 32'h7);
        repeat (10) @(posedge i_clock);
        chk(32'({isz, dsz}), 32'h21);
        rd(`RSB_CAUSE_OFS, 32'h8, 2'h0);
        pins <= 4'h5;
        fl_delay <= 4'h5;
        wr(`RSB_ASYNC_CTRL_OFS, 32'h9, 2'h0);
        for (m = 0; m < 10 && sys_n !== 1'h0; m++) @(posedge i_clock);
        lim(m, 10);
        for (m = 0; m < 50 && sys_n !== 1'h1; m++) @(posedge i_clock);
        chk(32'(m), 32'h4);
        rd(`RSB_CAUSE_OFS, 32'h2, 2'h0);
        rd(`RSB_BOOT_OFS, 32'h10, 2'h0);
        for (m = 0; m < 100 && br_valid !== 1'h1; m++) @(posedge i_clock);
        lim(m, 100);
        chk(32'(width), 32'(`RSB_WIDTH_16));
        wr(`RSB_WD_PERIOD_OFS, 32'd20, 2'h0);
        wr(`RSB_WD_PREWARN_OFS, 32'h5, 2'h0);
        wr(`RSB_ASYNC_CTRL_OFS, 32'h0, 2'h0);
        wr(`RSB_WD_CTRL_OFS, 32'h3, 2'h0);
        for (m = 0; m < 60 && pin !== 1'h1; m++) @(posedge i_clock);
        chk(32'({irq, pin, wd_x}), 32'h6);
        for (m = 0; m < 20 && sys_n !== 1'h0; m++) @(posedge i_clock);
        lim(m, 20);
        chk(32'(sw_n), 32'h1);
        repeat (10) @(posedge i_clock);
        rd(`RSB_CAUSE_OFS, 32'h1, 2'h0);
        wr(`RSB_ASYNC_CTRL_OFS, 32'h2, 2'h0);
        for (m = 0; m < 10 && sw_n !== 1'h0; m++) @(posedge i_clock);
        chk(32'({sw_n, sys_n}), 32'h1);
        repeat (10) @(posedge i_clock);
        rd(`RSB_ASYNC_CTRL_OFS, 32'h8, 2'h0);
        wr(`RSB_WD_CTRL_OFS, 32'h1, 2'h0);
        wr(`RSB_WD_RELOAD_OFS, 32'h0, 2'h0);
        for (m = 0; m < 40 && wd_x !== 1'h1; m++) @(posedge i_clock);
        lim(m, 40);
        for (m = 0; m < 8; m++) begin
            @(posedge i_clock);
            chk(32'(sys_n), 32'h1);
        end
        wr(`RSB_WD_CTRL_OFS, 32'h0, 2'h0);
        wr(`RSB_ASYNC_CTRL_OFS, 32'h0, 2'h0);
        for (i = 0; i < 3; i++) begin
            por(PINS[i], CFGS[i], 4'h5);
            repeat (WAIT + 20) @(posedge i_clock);
            rd(`RSB_BOOT_STAT_OFS, STAT[i], 2'h0);
            rd(`RSB_BOOT_OFS, 32'({CFGS[i], PINS[i]}), 2'h0);
            rd(`RSB_CAUSE_OFS, 32'h4, 2'h0);
            rd(`RSB_ASYNC_CTRL_OFS, 32'h8, 2'h0);
        end
        tally_and_finish();
    end
endmodule
`default_nettype wire
